/* File: verilog/mac_acc_access.sv */
// Accumulator access block: byte-wide load and unload of the 40-bit accumulator,
// load and read shifts, and the staging/computing bank status progression.
// Assumes the core presents one-cycle rd/wr strobes synchronous to clk_sys and
// marks the final access of a block transfer with last; the datapath pulses computing_bank_done.
// computing_bank_result is looked at only in a cycle with computing_bank_done high.
// Bit 7 of the control register reads back as zero.
//
// Operation
// - Completion with staging DONE and computing running sets computing DONE.
// - Block input ending on an accumulator byte read empties a DONE staging bank.
// - A single read of the top accumulator byte empties a DONE staging bank.
// - Writing any non-status register while staging DONE empties it, discarding result.
// - Control bits 2:0 select load left shift of 0 to 7 places.
// - Control bit 6 supplies the fill for low bits vacated by load shift.
// - Unshifted writes of bytes 0..4 load accumulator bits 7:0 through 39:32.
// - Shifted writes land s places higher; byte 0 fills low s bits, byte 4 drops overflow.
// - Five byte transfers load/unload 40 bits, shift crossing bytes automatically.
// - Control bits 5:3 select read right shift of 0 to 7 places.
// - Read shift fills vacated high bits with copies of bit 39.
// - Unshifted reads of bytes 0..4 return bits 7:0 through 39:32.
// - Writing 80h to status with staging EMPTY, computing DONE swaps banks.
// - Completion with staging READY swaps, marks staging DONE, starts queued work.
module mac_acc_access
	import mac_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire mac_req_t     req,
	output logic [7:0]        rdata,
	input  wire logic         computing_bank_done,
	input  wire logic [39:0]  computing_bank_result,
	output logic              computing_bank_start,
	output logic [39:0]       computing_bank_init_acc,
	output logic [7:0]        ctl_value
);

	// Byte k written with load shift s lands at bit 8k+s; byte 0 also fills the low s bits
	function automatic logic [39:0] mac_load(
		input logic [39:0] acc,
		input logic [2:0]  k,
		input logic [2:0]  s,
		input logic        fill,
		input logic [7:0]  d
	);
		logic [5:0]  pos;
		logic [39:0] m;
		logic [39:0] v;
		logic [39:0] low;
		pos = {k, 3'b000} + {3'b000, s};
		// Bits pushed past 39 fall off the mask, so the top s bits of byte 4 are lost
		m   = MAC_BYTE_MASK << pos;
		v   = {32'h0000_0000, d} << pos;
		low = ~(MAC_ALL_ONES << s);
		if (k == 3'b000) begin
			m = m | low;
			v = v | (fill ? low : MAC_ACC_RESET);
		end
		return (acc & ~m) | (v & m);
	endfunction

	logic [7:0]  ctl_q;
	logic [7:0]  ctl_d;
	logic [39:0] stg_acc_q;
	logic [39:0] stg_acc_d;
	logic [39:0] cmp_acc_q;
	logic [39:0] cmp_acc_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	// Bank states of the staging and computing banks
	mac_bank_t   stg_q;
	mac_bank_t   stg_d;
	mac_bank_t   cmp_q;
	mac_bank_t   cmp_d;
	logic        start_d;

	wire         is_acc   = (req.idx <= MAC_IDX_BYTE4);
	wire         is_top   = (req.idx == MAC_IDX_BYTE4);
	wire         is_ctl   = (req.idx == MAC_IDX_CONTROL);
	wire         is_stat  = (req.idx == MAC_IDX_STATUS);
	wire [2:0]   lsh      = ctl_q[MAC_CTL_LSH_LSB +: 3];
	wire [2:0]   rsh      = ctl_q[MAC_CTL_RSH_LSB +: 3];
	wire         fill     = ctl_q[MAC_CTL_FILL_BIT];
	// Reads see the staging bank; the arithmetic shift copies bit 39 downward
	wire [39:0]  rd_shift = 40'($signed(stg_acc_q) >>> rsh);
	wire [5:0]   rd_pos   = {req.idx[2:0], 3'b000};
	wire [7:0]   rd_byte  = rd_shift[rd_pos +: 8];
	wire [7:0]   stat_val = 8'({cmp_q, 2'b00, stg_q});
	// A definition ends on the last accumulator or control write of a block transfer, or on any top-byte write
	wire         wr_def   = req.wr && (is_acc || is_ctl) && (req.last || is_top);
	wire         wr_kill  = req.wr && !is_stat;
	wire         rd_take  = req.rd && is_acc && (req.last || is_top);
	wire         wr_acc   = req.wr && is_acc;
	wire         wr_ctl   = req.wr && is_ctl;
	// Other status values are dropped; 80h only acts in the one legal bank pairing
	wire         wr_swap  = req.wr && is_stat && (req.wdata == MAC_BANK_STATUS_ALIAS_SWAP_CMD);
	wire [7:0]   ctl_wr   = req.wdata & MAC_CTL_WR_MASK;

	assign rdata         = rdata_q;
	assign computing_bank_start    = start_d;
	assign computing_bank_init_acc = cmp_acc_q;
	assign ctl_value     = ctl_q;

	// Priority inside one cycle: datapath completion, then the core's register
	// effect, then the bank transition that effect triggers.
	// A write that empties a DONE staging bank is not also a new definition,
	// so software must read a result before defining new work or lose it.
	// A swap exchanges the two accumulator words rather than flipping a
	// pointer: 80 muxes more, but reads and the datapath view stay direct.
	always_comb begin
		logic [39:0] t;
		t         = MAC_ACC_RESET;
		ctl_d     = ctl_q;
		stg_d     = stg_q;
		cmp_d     = cmp_q;
		stg_acc_d = stg_acc_q;
		cmp_acc_d = cmp_acc_q;
		start_d   = 1'b0;
		rdata_d   = rdata_q;

		// Completion is applied first so same-cycle writes and read-empty checks see the new banks; read data does not
		if (computing_bank_done && cmp_d == MAC_IN_PROGRESS) begin
			if (stg_d == MAC_READY) begin
				cmp_acc_d = stg_acc_d;
				stg_acc_d = computing_bank_result;
				stg_d     = MAC_DONE;
				start_d   = 1'b1;
			end else begin
				cmp_acc_d = computing_bank_result;
				cmp_d     = MAC_DONE;
			end
		end

		if (wr_acc) begin
			stg_acc_d = mac_load(stg_acc_d, req.idx[2:0], lsh, fill, req.wdata);
		end
		if (wr_ctl) begin
			ctl_d = ctl_wr;
		end

		// Emptying a DONE staging bank outranks every other transition
		if (stg_d == MAC_DONE && wr_kill) begin
			stg_d = MAC_EMPTY;
		end else if (stg_d == MAC_DONE && rd_take) begin
			stg_d = MAC_EMPTY;
		end else if (wr_swap
				&& stg_d == MAC_EMPTY && cmp_d == MAC_DONE) begin
			t         = stg_acc_d;
			stg_acc_d = cmp_acc_d;
			cmp_acc_d = t;
			stg_d     = MAC_DONE;
			cmp_d     = MAC_EMPTY;
		end else if (wr_def && stg_d == MAC_EMPTY) begin
			case (cmp_d)
				MAC_IN_PROGRESS: begin
					stg_d = MAC_READY;
				end
				MAC_EMPTY, MAC_DONE: begin
					t         = stg_acc_d;
					stg_acc_d = cmp_acc_d;
					cmp_acc_d = t;
					stg_d     = (cmp_d == MAC_DONE) ? MAC_DONE : MAC_EMPTY;
					cmp_d     = MAC_IN_PROGRESS;
					start_d   = 1'b1;
				end
				default: begin
					stg_d = stg_d;
				end
			endcase
		end

		if (req.rd) begin
			if (is_acc) begin
				rdata_d = rd_byte;
			end else if (is_ctl) begin
				rdata_d = ctl_q;
			end else if (is_stat) begin
				rdata_d = stat_val;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q <= MAC_CTL_RESET;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stg_q <= MAC_EMPTY;
			cmp_q <= MAC_EMPTY;
		end else begin
			stg_q <= stg_d;
			cmp_q <= cmp_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stg_acc_q <= MAC_ACC_RESET;
			cmp_acc_q <= MAC_ACC_RESET;
		end else begin
			stg_acc_q <= stg_acc_d;
			cmp_acc_q <= cmp_acc_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

endmodule // mac_acc_access

/* File: verilog/mac_pkg.sv */
// Package for the accumulator access block: register indices, bank states, bus carrier.
// Assumes a byte-wide register port driven by the processor core.
package mac_pkg;

	// Register indices on the byte-wide register port
	localparam logic [3:0] MAC_IDX_BYTE0   = 4'h0;
	localparam logic [3:0] MAC_IDX_BYTE1   = 4'h1;
	localparam logic [3:0] MAC_IDX_BYTE2   = 4'h2;
	localparam logic [3:0] MAC_IDX_BYTE3   = 4'h3;
	localparam logic [3:0] MAC_IDX_BYTE4   = 4'h4;
	localparam logic [3:0] MAC_IDX_CONTROL = 4'h5;
	localparam logic [3:0] MAC_IDX_STATUS  = 4'h6;

	// Control register fields
	localparam int         MAC_CTL_LSH_LSB   = 0;
	localparam int         MAC_CTL_RSH_LSB   = 3;
	localparam int         MAC_CTL_FILL_BIT  = 6;
	localparam logic [7:0] MAC_CTL_RESET     = 8'h00;
	localparam logic [7:0] MAC_CTL_WR_MASK   = 8'h7f;

	// Status register: staging bank in [1:0], computing bank in [5:4]
	localparam int         MAC_BANK_STATUS_ALIAS_STG_LSB  = 0;
	localparam int         MAC_BANK_STATUS_ALIAS_CMP_LSB  = 4;
	localparam logic [7:0] MAC_BANK_STATUS_ALIAS_SWAP_CMD = 8'h80;

	localparam int         MAC_ACC_W         = 40;
	localparam int         MAC_ACC_MSB       = 39;
	localparam logic [39:0] MAC_ACC_RESET    = 40'h00_0000_0000;
	localparam logic [39:0] MAC_BYTE_MASK    = 40'h00_0000_00ff;
	localparam logic [39:0] MAC_ALL_ONES     = 40'hff_ffff_ffff;

	typedef enum logic [1:0] {
		MAC_EMPTY,
		MAC_READY,
		MAC_IN_PROGRESS,
		MAC_DONE
	} mac_bank_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       last;
		logic [3:0] idx;
		logic [7:0] wdata;
	} mac_req_t;

endpackage

/* File: verif/mac_acc_checker.sv */
// Checker for the accumulator access block, bound to its top ports.
// Assumes one clock domain and an active-low asynchronous reset.
module mac_acc_checker
	import mac_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire mac_req_t    req,
	input wire logic [7:0]  rdata,
	input wire logic        computing_bank_done,
	input wire logic [39:0] computing_bank_result,
	input wire logic        computing_bank_start,
	input wire logic [39:0] computing_bank_init_acc,
	input wire logic [7:0]  ctl_value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// No last and no completion, so no swap can move the control copy
	sequence s_ctl_wr;
		req.wr && req.idx == MAC_IDX_CONTROL && !req.last && !computing_bank_done;
	endsequence
	sequence s_rd(logic [3:0] i);
		req.rd && req.idx == i;
	endsequence
	sequence s_top_start;
		computing_bank_start && req.wr && req.idx == MAC_IDX_BYTE4 && !computing_bank_done;
	endsequence
	AST_CTL_WR: assert property (s_ctl_wr |=> ctl_value == ($past(req.wdata) & MAC_CTL_WR_MASK))
		else $error("control write not stored");
	AST_CTL_RD: assert property (s_rd(MAC_IDX_CONTROL) |=> rdata == $past(ctl_value))
		else $error("control read wrong");
	AST_STAT_FMT: assert property (s_rd(MAC_IDX_STATUS) |=> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00)
		else $error("status layout wrong");
	AST_RD_HOLD: assert property (!req.rd |=> $stable(rdata))
		else $error("read data moved without a read");
	AST_START_CAUSE: assert property (computing_bank_start |-> req.wr || computing_bank_done)
		else $error("start without a cause");
	AST_INIT_TOP: assert property (s_top_start |=> (computing_bank_init_acc[39:32] >> $past(ctl_value[2:0]))
		== ($past(req.wdata) & (8'hff >> $past(ctl_value[2:0]))))
		else $error("top byte load wrong");
	AST_RESET: assert property ($rose(rst_b) |-> ctl_value == MAC_CTL_RESET && !computing_bank_start)
		else $error("reset state wrong");
	AST_RD_UNMAP: assert property (req.rd && req.idx > MAC_IDX_STATUS |=> rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // mac_acc_checker
bind mac_acc_access mac_acc_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
	.computing_bank_done(computing_bank_done), .computing_bank_result(computing_bank_result), .computing_bank_start(computing_bank_start),
	.computing_bank_init_acc(computing_bank_init_acc), .ctl_value(ctl_value));

/* File: verif/mac_computing_bank_model.sv */
// Datapath stand-in: answers each computing_bank_start with one done pulse and a fixed result.
// Assumes computing_bank_start is sampled on clk_sys rising edges.
module mac_computing_bank_model #(
	parameter int          LAT = 20,
	parameter logic [39:0] RES = 40'h80_1234_5678
) (
	input  wire logic   clk_sys,
	input  wire logic   computing_bank_start,
	output logic        computing_bank_done,
	output logic [39:0] computing_bank_result
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial {computing_bank_done, computing_bank_result} = '0;
	always @(posedge clk_sys) begin
		computing_bank_done <= (cnt == 1);
		computing_bank_result <= (cnt == 1) ? RES : ~RES; // Outside the pulse the result is junk
		cnt <= computing_bank_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule // mac_computing_bank_model

/* File: verif/mac_acc_access_bench.sv */
// Bench for the accumulator access block: register accesses and bank status walk.
// Assumes mac_pkg, the design, the datapath model and the checker are compiled first.
module mac_acc_access_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mac_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	mac_req_t    req = '0;
	logic [7:0]  rdata, ctl_value, rd_v;
	logic        computing_bank_done, computing_bank_start;
	logic [39:0] computing_bank_result, computing_bank_init_acc, exp_v;
	int          err_total = 0;
	int          check_count = 0;
	always #2 clk_sys = ~clk_sys;
	mac_acc_access dut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .computing_bank_done(computing_bank_done),
		.computing_bank_result(computing_bank_result), .computing_bank_start(computing_bank_start), .computing_bank_init_acc(computing_bank_init_acc), .ctl_value(ctl_value));
	mac_computing_bank_model u_computing_bank (.clk_sys(clk_sys), .computing_bank_start(computing_bank_start), .computing_bank_done(computing_bank_done),
		.computing_bank_result(computing_bank_result));
	task automatic access(input logic wr, input logic [3:0] idx, input logic [7:0] d, input logic last);
		@(posedge clk_sys);
		req <= '{wr: wr, rd: !wr, last: last, idx: idx, wdata: d};
		@(posedge clk_sys);
		req <= '0;
		#1 rd_v = rdata;
	endtask
	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stat(input logic [7:0] e);
		access(1'b0, MAC_IDX_STATUS, 8'h00, 1'b0);
		cmp(40'(rd_v), 40'(e));
	endtask
	task automatic complete_run;
		$display("counts: %0d checks, %0d mismatches", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		stat(8'h00);
		access(1'b0, MAC_IDX_CONTROL, 8'h00, 1'b0);
		cmp(40'(rd_v), 40'h00);
		access(1'b0, 4'h7, 8'h00, 1'b0);
		cmp(40'(rd_v), 40'h00);
		$display("test reset done");
		access(1'b1, MAC_IDX_CONTROL, 8'h5b, 1'b0);
		for (int k = 0; k < 5; k++) access(1'b1, k[3:0], 8'h12 + 8'h22 * 8'(k), 1'b0);
		cmp(computing_bank_init_acc, (40'h9a_7856_3412 << 3) | 40'h7);
		stat(8'h20);
		access(1'b1, MAC_IDX_BYTE4, 8'h00, 1'b1);
		stat(8'h21);
		$display("test load done");
		for (int i = 0; i < 40 && computing_bank_start !== 1'b1; i++) @(posedge clk_sys) #1;
		cmp(40'(computing_bank_start), 40'h1);
		stat(8'h23);
		for (int i = 0; i < 40 && computing_bank_done !== 1'b1; i++) @(posedge clk_sys) #1;
		stat(8'h33);
		$display("test completion done");
		exp_v = $signed(40'h80_1234_5678) >>> 3;
		for (int k = 0; k < 5; k++) begin
			access(1'b0, k[3:0], 8'h00, 1'b0);
			cmp(40'(rd_v), 40'(exp_v[8*k +: 8]));
		end
		stat(8'h30);
		access(1'b1, MAC_IDX_STATUS, MAC_BANK_STATUS_ALIAS_SWAP_CMD, 1'b0);
		stat(8'h03);
		access(1'b1, 4'h7, 8'h00, 1'b0);
		stat(8'h00);
		$display("test unload done");
		access(1'b1, MAC_IDX_CONTROL, 8'h00, 1'b1);
		for (int i = 0; i < 40 && computing_bank_done !== 1'b1; i++) @(posedge clk_sys) #1;
		stat(8'h30);
		access(1'b1, MAC_IDX_STATUS, MAC_BANK_STATUS_ALIAS_SWAP_CMD, 1'b0);
		access(1'b0, MAC_IDX_BYTE0, 8'h00, 1'b1);
		cmp(40'(rd_v), 40'h78);
		stat(8'h00);
		$display("test block read done");
		complete_run();
	end
endmodule // mac_acc_access_bench
